// ==== stc_pkg.sv ====
// Constants, field positions and state types of the serial trim chain
package stc_pkg;

  // Frame geometry, counted in strobes
  localparam int FRAME_LEN   = 60;
  localparam int MEANINGFUL  = 58;
  localparam int LEAD_SKIP   = 2;

  // Load positions in shift order (position 0 is the first bit shifted in)
  localparam int POS_FINE    = 2;   // 6 bits, msb first
  localparam int POS_BAL     = 8;   // 9 bits, lsb first
  localparam int POS_FB      = 17;  // 10 bits, lsb first
  localparam int POS_GSEL    = 28;
  localparam int POS_BW      = 31;  // 4 bits, lsb first
  localparam int POS_REF     = 35;
  localparam int POS_OFF     = 36;  // 5 bits, msb first
  localparam int POS_GTRIM   = 41;  // 8 bits, msb first
  localparam int POS_THIRD   = 50;  // 3 bits, msb first
  localparam int POS_FOURTH  = 53;  // 4 bits, lsb first
  localparam int POS_FIFTH   = 57;  // 3 bits, lsb first

  // Field widths
  localparam int W_FINE      = 6;
  localparam int W_BAL       = 9;
  localparam int W_FB        = 10;
  localparam int W_BW        = 4;
  localparam int W_OFF       = 5;
  localparam int W_GTRIM     = 8;
  localparam int W_THIRD     = 3;
  localparam int W_FOURTH    = 4;
  localparam int W_FIFTH     = 3;

  // Highest legal bandwidth code
  localparam logic [W_BW-1:0] BW_MAX_CODE = 4'h8;

  // Reset values
  localparam logic [FRAME_LEN-1:0] CHAIN_RESET = 60'h0;
  // Synchroniser order {chip reset, select_n, toggle}; pins idle at their pulls
  localparam logic [2:0] SYNC_RESET = 3'h6;

  typedef struct packed {
    logic                 toggle;
    logic [FRAME_LEN-1:0] chain;
  } stc_link_t;

  typedef struct packed {
    logic bit_out;
  } stc_read_t;

  typedef struct packed {
    logic                 seen;
    logic                 direct;
    logic                 drive_n;
    logic [FRAME_LEN-1:0] image;
    logic [W_FINE-1:0]    fine;
    logic [W_BAL-1:0]     bal;
    logic [W_FB-1:0]      fb;
    logic                 gsel;
    logic [W_BW-1:0]      bw;
    logic                 bw_bad;
    logic                 ref_sel;
    logic [W_OFF-1:0]     off;
    logic [W_GTRIM-1:0]   gtrim;
    logic [W_THIRD-1:0]   third;
    logic [W_FOURTH-1:0]  fourth;
    logic [W_FIFTH-1:0]   fifth;
  } stc_main_t;

endpackage : stc_pkg

// ==== stc_sync.sv ====
// Two-stage level synchroniser with a frozen state under clock enable
`timescale 1ns/1ns
`default_nettype none
module stc_sync #(
  parameter int               WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic             clock,        // Destination clock
  input  wire logic             reset_n,      // Asynchronous reset, active low
  input  wire logic             clock_enable, // Freezes both stages while low
  input  wire logic [WIDTH-1:0] async_in,     // Level from another domain
  output logic      [WIDTH-1:0] sync_out      // Synchronised level
);

  logic [1:0][WIDTH-1:0] stage;
  logic [1:0][WIDTH-1:0] next_stage;

  always_comb begin
    next_stage = stage;
    if (clock_enable) begin
      next_stage[0] = async_in;
      next_stage[1] = stage[0];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stage <= {RESET_VALUE, RESET_VALUE};
    end else begin
      stage <= next_stage;
    end
  end

  assign sync_out = stage[1];

endmodule : stc_sync
`default_nettype wire

// ==== stc_trim_chain.sv ====
// Serial trim chain: volatile load, readback and trim output selection
`timescale 1ns/1ns
`default_nettype none
module stc_trim_chain
  import stc_pkg::*;
(
  input  wire logic                 clock,                  // System clock, 100 MHz
  input  wire logic                 reset_n,                // Asynchronous reset, active low
  input  wire logic                 clock_enable,           // Freezes system state while low
  input  wire logic                 serial_clock,           // Link clock from the programmer
  input  wire logic                 serial_in_pin,          // Serial data, link domain
  input  wire logic                 direct_load_select_n,   // Test select pin, active low
  input  wire logic                 chip_reset_pin,         // Chip reset pin, active low
  input  wire logic                 high_voltage_program_input, // Unused in this mode
  input  wire logic                 program_select_readback_pin_in, // Write-select pin level
  output logic                      program_select_readback_pin_out, // Readback data
  output logic                      program_select_readback_pin_oe_n, // Low while driving
  output logic                      program_select_sense,   // Write-select seen as input
  input  wire logic [FRAME_LEN-1:0] nonvolatile_word,       // Stored settings, load layout
  output logic      [W_FINE-1:0]    fine_cap_code,          // Trim capacitor code
  output logic      [W_BAL-1:0]     balance_cap_code,       // Balance capacitor code
  output logic      [W_FB-1:0]      feedback_cap_code,      // Feedback capacitor code
  output logic                      nominal_gain_select,    // 1: gain 4, 0: gain 2
  output logic      [W_BW-1:0]      filter_bandwidth_code,  // Filter bandwidth code
  output logic                      filter_bandwidth_invalid, // Code in unused range
  output logic                      output_reference_select, // 0: 2.25V, 1: 0.5V
  output logic      [W_OFF-1:0]     output_offset_trim,     // Offset trim code
  output logic      [W_GTRIM-1:0]   gain_trim_code,         // Gain trim code
  output logic      [W_THIRD-1:0]   third_group_bits,       // Third group
  output logic      [W_FOURTH-1:0]  fourth_group_bits,      // Fourth group
  output logic      [W_FIFTH-1:0]   fifth_group_bits,       // Fifth group
  output logic                      direct_mode             // Volatile chain in use
);

  ////////////////////////////////////////////////////////////////////////////
  // Field extraction, position counted in shift order

  function automatic logic [9:0] field_up(input logic [FRAME_LEN-1:0] word,
                                          input int pos, input int width);
    logic [9:0] value;
    value = 10'h0;
    for (int i = 0; i < 10; i++) begin
      if (i < width) begin
        value[i] = word[FRAME_LEN-1-(pos+i)];
      end
    end
    return value;
  endfunction : field_up

  function automatic logic [9:0] field_down(input logic [FRAME_LEN-1:0] word,
                                            input int pos, input int width);
    logic [9:0] value;
    value = 10'h0;
    for (int i = 0; i < 10; i++) begin
      if (i < width) begin
        value[width-1-i] = word[FRAME_LEN-1-(pos+i)];
      end
    end
    return value;
  endfunction : field_down

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: shift chain on the rising serial clock

  stc_link_t link;
  stc_link_t next_link;

  // The chain shifts on every strobe, whatever the select; stored-memory
  // programming also clocks it, which is harmless because it is unused then.
  always_comb begin
    next_link        = link;
    next_link.chain  = {link.chain[FRAME_LEN-2:0], serial_in_pin};
    next_link.toggle = ~link.toggle;
  end

  // First bit in ends deepest; a 58-strobe frame leaves the two top bits
  // stale, and those only ever hold don't-care positions.
  always_ff @(posedge serial_clock or negedge reset_n) begin
    if (!reset_n) begin
      link <= '{toggle: 1'b0, chain: CHAIN_RESET};
    end else begin
      link <= next_link;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: readback launched on the falling serial clock

  stc_read_t rd;
  stc_read_t next_rd;

  // Tap at the first meaningful position so readback position j is load
  // position j plus two; shifting then walks the frame out in order.
  always_comb begin
    next_rd         = rd;
    next_rd.bit_out = link.chain[FRAME_LEN-1-LEAD_SKIP];
  end

  always_ff @(negedge serial_clock or negedge reset_n) begin
    if (!reset_n) begin
      rd <= '{bit_out: 1'b0};
    end else begin
      rd <= next_rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Crossing into the system domain

  logic [2:0] sync_bus;
  logic       chip_run_s;
  logic       select_n_s;
  logic       toggle_s;

  // Reset values match the pin pulls: chip reset high, select high.
  stc_sync #(
    .WIDTH       (3),
    .RESET_VALUE (SYNC_RESET)
  ) u_sync (
    .clock        (clock),
    .reset_n      (reset_n),
    .clock_enable (clock_enable),
    .async_in     ({chip_reset_pin, direct_load_select_n, link.toggle}),
    .sync_out     (sync_bus)
  );

  assign chip_run_s = sync_bus[2];
  assign select_n_s = sync_bus[1];
  assign toggle_s   = sync_bus[0];

  ////////////////////////////////////////////////////////////////////////////
  // System domain: chain image and active trims

  stc_main_t st;
  stc_main_t next_st;
  logic [FRAME_LEN-1:0] source;

  // The chain is sampled after the toggle has crossed; it is then stable
  // until the next rising strobe, which needs a link period of at least
  // four system cycles.
  always_comb begin
    next_st = st;
    source  = st.direct ? st.image : nonvolatile_word;
    if (clock_enable) begin
      next_st.seen    = toggle_s;
      next_st.direct  = ~select_n_s;
      next_st.drive_n = select_n_s;
      if (toggle_s != st.seen) begin
        next_st.image = link.chain;
      end
      next_st.fine    = W_FINE'(field_down(source, POS_FINE, W_FINE));
      next_st.bal     = W_BAL'(field_up(source, POS_BAL, W_BAL));
      next_st.fb      = W_FB'(field_up(source, POS_FB, W_FB));
      next_st.gsel    = source[FRAME_LEN-1-POS_GSEL];
      next_st.bw      = W_BW'(field_up(source, POS_BW, W_BW));
      next_st.bw_bad  = next_st.bw > BW_MAX_CODE;
      next_st.ref_sel = source[FRAME_LEN-1-POS_REF];
      next_st.off     = W_OFF'(field_down(source, POS_OFF, W_OFF));
      next_st.gtrim   = W_GTRIM'(field_down(source, POS_GTRIM, W_GTRIM));
      next_st.third   = W_THIRD'(field_down(source, POS_THIRD, W_THIRD));
      next_st.fourth  = W_FOURTH'(field_up(source, POS_FOURTH, W_FOURTH));
      next_st.fifth   = W_FIFTH'(field_up(source, POS_FIFTH, W_FIFTH));
      if (!chip_run_s) begin
        next_st = '0;
        next_st.seen    = toggle_s;
        next_st.drive_n = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st <= '{drive_n: 1'b1, default: '0};
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Readback data only leaves while the pin is turned round; the pin is
  // an input for stored-memory programming otherwise.
  assign program_select_readback_pin_out  = rd.bit_out;
  assign program_select_readback_pin_oe_n = st.drive_n;
  // Write-select and high voltage take no part in direct loading.
  assign program_select_sense = program_select_readback_pin_in & st.drive_n &
                                ~high_voltage_program_input;

  assign fine_cap_code            = st.fine;
  assign balance_cap_code         = st.bal;
  assign feedback_cap_code        = st.fb;
  assign nominal_gain_select      = st.gsel;
  assign filter_bandwidth_code    = st.bw;
  assign filter_bandwidth_invalid = st.bw_bad;
  assign output_reference_select  = st.ref_sel;
  assign output_offset_trim       = st.off;
  assign gain_trim_code           = st.gtrim;
  assign third_group_bits         = st.third;
  assign fourth_group_bits        = st.fourth;
  assign fifth_group_bits         = st.fifth;
  assign direct_mode              = st.direct;

endmodule : stc_trim_chain
`default_nettype wire

// ==== stc_trim_chain_monitor.sv ====
// Port checks of the serial trim chain, bound to its top module
`timescale 1ns/1ns
`default_nettype none
module stc_trim_chain_monitor
  import stc_pkg::*;
(
  input wire logic              clock, // System clock
  input wire logic              reset_n, // Async reset
  input wire logic              clock_enable, // State enable
  input wire logic              serial_clock, // Link clock
  input wire logic              serial_in_pin, // Serial data
  input wire logic              direct_load_select_n, // Test select
  input wire logic              chip_reset_pin, // Chip reset
  input wire logic              high_voltage_program_input, // Supply pin
  input wire logic              program_select_readback_pin_in, // Pin level
  input wire logic              program_select_readback_pin_out, // Readback bit
  input wire logic              program_select_readback_pin_oe_n, // Pin enable
  input wire logic              program_select_sense, // Pin as input
  input wire logic [W_FINE-1:0] fine_cap_code, // Trim cap
  input wire logic [W_BW-1:0]   filter_bandwidth_code, // Bandwidth
  input wire logic              filter_bandwidth_invalid, // Unused code
  input wire logic              direct_mode // Chain in use
);
  // Readback is judged only once the chain holds bits strobed in since reset
  logic [5:0] strobes;
  always_ff @(posedge serial_clock or negedge reset_n) begin
    if (!reset_n) strobes <= 6'h0;
    else if (strobes != 6'h3f) strobes <= strobes + 6'h1;
  end
  ////////////////////////////////////////////////////////////
  a_readback_order: assert property (@(posedge serial_clock) disable iff (!reset_n)
    strobes >= 6'h3a |-> program_select_readback_pin_out == $past(serial_in_pin, 58))
    else $error("readback bit out of order");
  a_bw_flag: assert property (@(posedge clock) disable iff (!reset_n)
    filter_bandwidth_invalid == (filter_bandwidth_code > 4'h8))
    else $error("bandwidth flag wrong");
  a_sense_gate: assert property (@(posedge clock) disable iff (!reset_n)
    program_select_sense == (program_select_readback_pin_in
      && program_select_readback_pin_oe_n && !high_voltage_program_input))
    else $error("write select sensed while driven");
  a_mode_on: assert property (@(posedge clock) disable iff (!reset_n)
    (!direct_load_select_n && chip_reset_pin && clock_enable) [*5] |-> direct_mode)
    else $error("direct mode not entered");
  a_mode_off: assert property (@(posedge clock) disable iff (!reset_n)
    (direct_load_select_n && clock_enable) [*4] |-> !direct_mode)
    else $error("direct mode not left");
  a_drive_on: assert property (@(posedge clock) disable iff (!reset_n)
    (!direct_load_select_n && chip_reset_pin && clock_enable) [*5]
      |-> !program_select_readback_pin_oe_n)
    else $error("readback pin not driven");
  a_drive_off: assert property (@(posedge clock) disable iff (!reset_n)
    (direct_load_select_n && clock_enable) [*4] |-> program_select_readback_pin_oe_n)
    else $error("readback pin driven outside test mode");
  a_chip_clear: assert property (@(posedge clock) disable iff (!reset_n)
    (!chip_reset_pin && clock_enable) [*4] |-> fine_cap_code == '0 && filter_bandwidth_code == '0)
    else $error("chip reset left trims set");
endmodule : stc_trim_chain_monitor
bind stc_trim_chain stc_trim_chain_monitor u_monitor (.clock, .reset_n, .clock_enable,
  .serial_clock, .serial_in_pin, .direct_load_select_n, .chip_reset_pin,
  .high_voltage_program_input, .program_select_readback_pin_in,
  .program_select_readback_pin_out, .program_select_readback_pin_oe_n, .program_select_sense,
  .fine_cap_code, .filter_bandwidth_code, .filter_bandwidth_invalid, .direct_mode);
`default_nettype wire

// ==== stc_programmer_model.sv ====
// Behavioural model of the external programmer on the serial link
`timescale 1ns/1ns
`default_nettype none
module stc_programmer_model (
  input  wire logic        go, // Start a frame
  input  wire logic [59:0] frame, // Position p at bit 59-p
  input  wire logic [5:0]  nbits, // Strobes, 60 or 58
  input  wire logic        readback_pin, // Write-select level
  output logic             serial_clock, // Low between frames
  output logic             serial_in_pin, // Serial data
  output logic [59:0]      captured, // Newest bit in bit 0
  output logic             busy // Frame running
);
  // One process owns every output, so each has a single driver
  initial begin
    serial_clock = 1'b0;
    serial_in_pin = 1'b0;
    captured = 60'h0;
    busy = 1'b0;
    // Short frames drop the leading don't-care positions; the supply and write-select
    // pins are never touched, since they take no part in a direct load
    forever begin
      @(posedge go);
      busy = 1'b1;
      #13;
      for (int i = 60 - nbits; i < 60; i++) begin
        serial_in_pin = frame[59 - i];
        #40 serial_clock = 1'b1;
        #39 serial_clock = 1'b0;
        #1 captured = {captured[58:0], readback_pin};
      end
      serial_in_pin = 1'b0;
      busy = 1'b0;
    end
  end
endmodule : stc_programmer_model
`default_nettype wire

// ==== stc_trim_chain_test.sv ====
// Self-checking testbench of the serial trim chain
`timescale 1ns/1ns
`default_nettype none
module stc_trim_chain_test;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic        sel_n = 1'b1;
  logic        chip_rst = 1'b1;
  logic        hv = 1'b0;
  logic        ce = 1'b1;
  logic        wrt_drive = 1'b0;
  logic        go = 1'b0;
  logic [5:0]  nbits = 6'h3c;
  logic [59:0] nv = 60'h0;
  logic [59:0] frame = 60'h0;
  logic [59:0] f;
  logic [59:0] g;
  int          n_errors = 0;
  int          comparisons = 0;
  wire         serial_clock, serial_in, rb_out, oe_n, sense, dmode, busy;
  wire [59:0]  captured;
  wire [54:0]  fields;
  // Pin shows the readback bit while the device drives it, else the bench level
  wire         wrt_pin = oe_n ? wrt_drive : rb_out;

  always #5 clock = ~clock;

  stc_trim_chain DUT (.clock(clock), .reset_n(reset_n), .clock_enable(ce),
    .serial_clock(serial_clock), .serial_in_pin(serial_in), .direct_load_select_n(sel_n),
    .chip_reset_pin(chip_rst), .high_voltage_program_input(hv),
    .program_select_readback_pin_in(wrt_pin), .program_select_readback_pin_out(rb_out),
    .program_select_readback_pin_oe_n(oe_n), .program_select_sense(sense),
    .nonvolatile_word(nv), .fine_cap_code(fields[54:49]), .balance_cap_code(fields[48:40]),
    .feedback_cap_code(fields[39:30]), .nominal_gain_select(fields[29]),
    .filter_bandwidth_code(fields[28:25]), .filter_bandwidth_invalid(fields[24]),
    .output_reference_select(fields[23]), .output_offset_trim(fields[22:18]),
    .gain_trim_code(fields[17:10]), .third_group_bits(fields[9:7]),
    .fourth_group_bits(fields[6:3]), .fifth_group_bits(fields[2:0]), .direct_mode(dmode));
  stc_programmer_model programmer (.go(go), .frame(frame), .nbits(nbits), .readback_pin(wrt_pin),
    .serial_clock(serial_clock), .serial_in_pin(serial_in), .captured(captured), .busy(busy));
  ////////////////////////////////////////////////////////////
  function automatic logic [9:0] take(input logic [59:0] w, input int p, input int n,
                                      input logic msb);
    take = 10'h0;
    for (int k = 0; k < n; k++) take[msb ? n - 1 - k : k] = w[59 - p - k];
  endfunction : take

  function automatic logic [54:0] expect_fields(input logic [59:0] w);
    logic [3:0] bw;
    bw = 4'(take(w, 31, 4, 1'b0));
    expect_fields = {6'(take(w, 2, 6, 1'b1)), 9'(take(w, 8, 9, 1'b0)), 10'(take(w, 17, 10, 1'b0)),
      w[31], bw, bw > 4'h8, w[24], 5'(take(w, 36, 5, 1'b1)), 8'(take(w, 41, 8, 1'b1)),
      3'(take(w, 50, 3, 1'b1)), 4'(take(w, 53, 4, 1'b0)), 3'(take(w, 57, 3, 1'b0))};
  endfunction : expect_fields

  task automatic check(input logic [63:0] got, input logic [63:0] want);
    comparisons++;
    if (got !== want) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, want);
    end
  endtask : check

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  // A frame of 60 strobes takes about 480 system cycles, so 2000 means a hang
  task automatic send(input logic [59:0] bits, input logic [5:0] n);
    frame <= bits;
    nbits <= n;
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    for (int t = 0; t < 2000 && busy; t++) @(posedge clock);
    if (busy) begin
      n_errors++;
      conclude();
    end
    repeat (10) @(posedge clock);
  endtask : send

  initial begin
    void'($urandom(32'hb840));
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    check({fields, oe_n, dmode}, {55'h0, 2'b10});
    for (int i = 0; i < 3; i++) begin
      nv <= 60'({$urandom, $urandom});
      wrt_drive <= 1'($urandom);
      hv <= 1'($urandom);
      repeat (8) @(posedge clock);
      check(fields, expect_fields(nv));
      check({dmode, sense}, {1'b0, wrt_drive & ~hv});
    end
    $display("stored settings test done");
    sel_n <= 1'b0;
    hv <= 1'b0;
    repeat (8) @(posedge clock);
    check({dmode, oe_n}, 2'b10);
    for (int i = 0; i < 6; i++) begin
      // Corners: all ones, all zeros, bandwidth code at the limit and one above
      f = (i == 0) ? '1 : (i == 1) ? '0 : (i == 2) ? 60'h2000000 :
          (i == 3) ? 60'h12000000 : 60'({$urandom, $urandom});
      send(f, 6'h3c);
      check(fields, expect_fields(f));
    end
    g = 60'({$urandom, $urandom});
    send(g, 6'h3a);
    check(captured[58:1], f[57:0]);
    check(fields, expect_fields(g));
    // Clock enable low: leaving test mode must not reach the outputs
    ce <= 1'b0;
    sel_n <= 1'b1;
    repeat (8) @(posedge clock);
    check({fields, dmode, oe_n}, {expect_fields(g), 2'b10});
    ce <= 1'b1;
    sel_n <= 1'b0;
    repeat (8) @(posedge clock);
    check({dmode, oe_n}, 2'b10);
    $display("direct load and readback test done");
    chip_rst <= 1'b0;
    repeat (6) @(posedge clock);
    check(fields, 55'h0);
    chip_rst <= 1'b1;
    sel_n <= 1'b1;
    wrt_drive <= 1'b1;
    repeat (8) @(posedge clock);
    check(fields, expect_fields(nv));
    check({dmode, oe_n, sense}, 3'b011);
    $display("chip reset and return test done");
    conclude();
  end
endmodule : stc_trim_chain_test
`default_nettype wire
